// File: rtl/pagps_top.sv
// port a: registers, pin 7/6 function select, pin drivers, axi4-lite slave
module pagps_top
  import pagps_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // operating mode and standby
  input  wire logic [2:0]  mode_pins,
  input  wire logic        hw_standby,
  input  wire logic        sw_standby,
  // shared function sources
  input  wire logic        pattern_out_bit7,
  input  wire logic        pattern_out_bit6,
  input  wire logic        timer_ch2_b_out,
  input  wire logic        timer_ch2_a_out,
  input  wire logic        address_bit_twenty,
  input  wire logic        address_bit_twentyone,
  input  wire logic        chip_select_four_n,
  // timer capture inputs
  output logic             timer_ch2_b_capture,
  output logic             timer_ch2_a_capture,
  // port pins
  input  wire logic [7:0]  pa_in,
  output logic [7:0]       pa_out,
  output logic [7:0]       pa_oe_n
);

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  logic [2:0]  mode_reg;
  logic [7:0]  dir_reg;
  logic [7:0]  port_output_data_reg;
  pagps_ctrl_t ctrl_reg;
  logic [7:0]  dir_eff;
  logic        grp_addr;
  logic        rst_grp_addr;
  logic        b_cmp;
  logic        a_cmp;
  pagps_fn_t   pin_fn [8];

  logic        aw_hold_reg;
  logic        w_hold_reg;
  logic [3:0]  waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [1:0]  rresp_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [7:0]  port_read;
  logic        do_write;

  // -------------------------------------------------------------------
  // mode strap, caught while reset is held
  // -------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= mode_pins;
    end
  end

  function automatic logic addr_mode(input logic [2:0] m);
    return (m == 3'h3) || (m == 3'h4) || (m == 3'h6);
  endfunction

  assign grp_addr     = addr_mode(mode_reg);
  assign rst_grp_addr = addr_mode(mode_pins);

  // -------------------------------------------------------------------
  // register file
  // -------------------------------------------------------------------
  assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_reg <= rst_grp_addr ? PAGPS_DIR_RST_ADDR : PAGPS_DIR_RST_LOW;
    end else if (hw_standby) begin
      dir_reg <= grp_addr ? PAGPS_DIR_RST_ADDR : PAGPS_DIR_RST_LOW;
    end else if (do_write && !sw_standby && wstrb_reg[0]
                 && waddr_reg == PAGPS_OFS_DIR) begin
      dir_reg <= wdata_reg[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || hw_standby) begin
      port_output_data_reg <= PAGPS_DATA_RST;
    end else if (do_write && !sw_standby && wstrb_reg[0]
                 && waddr_reg == PAGPS_OFS_DATA) begin
      port_output_data_reg <= wdata_reg[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || hw_standby) begin
      ctrl_reg <= PAGPS_CTRL_RST;
    end else if (do_write && !sw_standby && waddr_reg == PAGPS_OFS_CTRL) begin
      if (wstrb_reg[0]) begin
        ctrl_reg[7:0] <= wdata_reg[7:0];
      end
      if (wstrb_reg[1]) begin
        ctrl_reg[10:8] <= wdata_reg[10:8];
      end
    end
  end

  // pin 7 direction pinned high in address modes
  assign dir_eff = {dir_reg[7] | grp_addr, dir_reg[6:0]};

  // -------------------------------------------------------------------
  // pin function selection
  // -------------------------------------------------------------------
  assign b_cmp = (!ctrl_reg.b_io[2] && (ctrl_reg.b_io[1:0] != 2'h0))
                 || ctrl_reg.ch2_pwm_mode_bit;
  assign a_cmp = (!ctrl_reg.a_io[2] && (ctrl_reg.a_io[1:0] != 2'h0))
                 || ctrl_reg.ch2_pwm_mode_bit;

  function automatic pagps_fn_t shared_fn(input logic cmp, input logic dir,
                                          input logic pat);
    if (cmp) begin
      return PAGPS_FN_TMR;
    end else if (!dir) begin
      return PAGPS_FN_IN;
    end else if (pat) begin
      return PAGPS_FN_PAT;
    end
    return PAGPS_FN_PORT;
  endfunction

  always_comb begin
    if (grp_addr) begin
      pin_fn[PAGPS_PIN7] = PAGPS_FN_ADDR;
    end else begin
      pin_fn[PAGPS_PIN7] = shared_fn(b_cmp, dir_eff[7],
                                     ctrl_reg.pin7_pattern_enable);
    end
  end

  always_comb begin
    if (mode_reg != 3'h7 && ctrl_reg.chip_select4_enable) begin
      pin_fn[PAGPS_PIN6] = PAGPS_FN_CS;
    end else if (grp_addr && !ctrl_reg.address_bit21_enable) begin
      pin_fn[PAGPS_PIN6] = PAGPS_FN_ADDR;
    end else begin
      pin_fn[PAGPS_PIN6] = shared_fn(a_cmp, dir_eff[6],
                                     ctrl_reg.pin6_pattern_enable);
    end
  end

  // -------------------------------------------------------------------
  // pin drivers, registered
  // -------------------------------------------------------------------
  for (genvar i = 0; i < 8; i++) begin : g_pin
    logic pat_v;
    logic tmr_v;
    logic adr_v;
    logic nxt_out;
    logic nxt_oe_n;

    if (i >= 6) begin : g_shared
      assign pat_v = (i == 7) ? pattern_out_bit7 : pattern_out_bit6;
      assign tmr_v = (i == 7) ? timer_ch2_b_out : timer_ch2_a_out;
      assign adr_v = (i == 7) ? address_bit_twenty : address_bit_twentyone;
    end else begin : g_plain
      assign pat_v = 1'b0;
      assign tmr_v = 1'b0;
      assign adr_v = 1'b0;
      assign pin_fn[i] = dir_eff[i] ? PAGPS_FN_PORT : PAGPS_FN_IN;
    end

    always_comb begin
      nxt_oe_n = 1'b0;
      unique case (pin_fn[i])
        PAGPS_FN_IN:   begin
          nxt_out  = 1'b0;
          nxt_oe_n = 1'b1;
        end
        PAGPS_FN_PORT: nxt_out = port_output_data_reg[i];
        PAGPS_FN_PAT:  nxt_out = pat_v;
        PAGPS_FN_TMR:  nxt_out = tmr_v;
        PAGPS_FN_ADDR: nxt_out = adr_v;
        PAGPS_FN_CS:   nxt_out = chip_select_four_n;
        default: begin
          nxt_out  = 1'b0;
          nxt_oe_n = 1'b1;
        end
      endcase
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        pa_out[i]  <= 1'b0;
        pa_oe_n[i] <= 1'b1;
      end else begin
        pa_out[i]  <= nxt_out;
        pa_oe_n[i] <= nxt_oe_n;
      end
    end

    assign port_read[i] = dir_eff[i] ? port_output_data_reg[i] : pa_in[i];
  end

  // -------------------------------------------------------------------
  // capture feeds
  // -------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_ch2_b_capture <= 1'b0;
      timer_ch2_a_capture <= 1'b0;
    end else begin
      timer_ch2_b_capture <= pa_in[7] && ctrl_reg.b_io[2]
                             && !ctrl_reg.ch2_pwm_mode_bit;
      timer_ch2_a_capture <= pa_in[6] && ctrl_reg.a_io[2];
    end
  end

  // -------------------------------------------------------------------
  // axi4-lite write channel
  // -------------------------------------------------------------------
  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      waddr_reg   <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_reg <= 1'b1;
      waddr_reg   <= {s_axi_awaddr[3:2], 2'h0};
    end else if (do_write) begin
      aw_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_reg <= 1'b0;
      wdata_reg  <= 32'h0;
      wstrb_reg  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_reg <= 1'b1;
      wdata_reg  <= s_axi_wdata;
      wstrb_reg  <= s_axi_wstrb;
    end else if (do_write) begin
      w_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= PAGPS_RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= (waddr_reg == PAGPS_OFS_STATUS) ? PAGPS_RESP_SLVERR
                                                    : PAGPS_RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // -------------------------------------------------------------------
  // axi4-lite read channel
  // -------------------------------------------------------------------
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  always_comb begin
    rdata_next = 32'h0;
    unique case ({s_axi_araddr[3:2], 2'h0})
      PAGPS_OFS_DIR:  rdata_next[7:0] = PAGPS_DIR_READ;
      PAGPS_OFS_DATA: rdata_next[7:0] = port_read;
      PAGPS_OFS_CTRL: rdata_next[10:0] = ctrl_reg;
      PAGPS_OFS_STATUS: begin
        rdata_next[PAGPS_ST_MODE_LSB +: 3] = mode_reg;
        rdata_next[PAGPS_ST_FN7_LSB +: 6]  = pin_fn[PAGPS_PIN7];
        rdata_next[PAGPS_ST_FN6_LSB +: 6]  = pin_fn[PAGPS_PIN6];
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= PAGPS_RESP_OKAY;
      rdata_reg  <= 32'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= PAGPS_RESP_OKAY;
      rdata_reg  <= rdata_next;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // -------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_dir_read_ones: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr[3:2] == 2'h0
    |=> s_axi_rvalid && s_axi_rdata == 32'h0000_00FF)
    else $error("direction read not all ones");

  a_dir_reset_low: assert property (disable iff (1'b0)
    $past(!aresetn) && !addr_mode(mode_reg) |-> dir_reg == 8'h00)
    else $error("direction not cleared by reset");

  a_dir_reset_addr: assert property (disable iff (1'b0)
    $past(!aresetn) && addr_mode(mode_reg) |-> dir_reg == 8'h80)
    else $error("direction not 0x80 after reset");

  a_pin7_addr_fixed: assert property (
    grp_addr |=> !pa_oe_n[7] && pa_out[7] == $past(address_bit_twenty))
    else $error("pin 7 not address output");

  a_standby_hold: assert property (
    sw_standby && !hw_standby ##1 sw_standby && !hw_standby
    |-> $stable(dir_reg) && $stable(port_output_data_reg))
    else $error("registers changed in software standby");

  a_hwstby_clear: assert property (
    hw_standby |=> port_output_data_reg == 8'h00)
    else $error("data not cleared in hardware standby");

  a_port_out_val: assert property (
    dir_reg[0] |=> !pa_oe_n[0] && pa_out[0] == $past(port_output_data_reg[0]))
    else $error("port output value wrong");

  a_input_release: assert property (
    !dir_reg[1] |=> pa_oe_n[1])
    else $error("input pin driven");

  a_port_read_mix: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr[3:2] == 2'h1
    |=> s_axi_rdata[7:0] == $past((dir_eff & port_output_data_reg)
                                  | (~dir_eff & pa_in)))
    else $error("port read mix wrong");

  a_pin7_timer: assert property (
    !grp_addr && !ctrl_reg.b_io[2] && ctrl_reg.b_io[1:0] != 2'h0
    |=> !pa_oe_n[7] && pa_out[7] == $past(timer_ch2_b_out))
    else $error("pin 7 not compare output");

  a_pin7_pattern: assert property (
    !grp_addr && !b_cmp && dir_reg[7] && ctrl_reg.pin7_pattern_enable
    |=> pa_out[7] == $past(pattern_out_bit7))
    else $error("pin 7 not pattern output");

  a_b_capture: assert property (
    ctrl_reg.ch2_pwm_mode_bit |=> !timer_ch2_b_capture)
    else $error("b capture active in pwm mode");

  a_a_capture: assert property (
    ctrl_reg.a_io[2] |=> timer_ch2_a_capture == $past(pa_in[6]))
    else $error("a capture not following pin 6");

  a_pin6_cs: assert property (
    mode_reg != 3'h7 && ctrl_reg.chip_select4_enable
    |=> !pa_oe_n[6] && pa_out[6] == $past(chip_select_four_n))
    else $error("pin 6 not chip select");

  a_pin6_addr21: assert property (
    grp_addr && !ctrl_reg.chip_select4_enable
    && !ctrl_reg.address_bit21_enable |-> pin_fn[PAGPS_PIN6] == PAGPS_FN_ADDR)
    else $error("pin 6 not address 21");

endmodule

// File: common/pagps_pkg.sv
// package: register map, field layout and pin function codes for port a
package pagps_pkg;

  // -------------------------------------------------------------------
  // register offsets
  // -------------------------------------------------------------------
  localparam logic [3:0] PAGPS_OFS_DIR    = 4'h0;
  localparam logic [3:0] PAGPS_OFS_DATA   = 4'h4;
  localparam logic [3:0] PAGPS_OFS_CTRL   = 4'h8;
  localparam logic [3:0] PAGPS_OFS_STATUS = 4'hC;

  // -------------------------------------------------------------------
  // reset values and fixed answers
  // -------------------------------------------------------------------
  localparam logic [7:0]  PAGPS_DIR_RST_LOW  = 8'h00;
  localparam logic [7:0]  PAGPS_DIR_RST_ADDR = 8'h80;
  localparam logic [7:0]  PAGPS_DATA_RST     = 8'h00;
  localparam logic [7:0]  PAGPS_DIR_READ     = 8'hFF;
  localparam logic [1:0]  PAGPS_RESP_OKAY    = 2'h0;
  localparam logic [1:0]  PAGPS_RESP_SLVERR  = 2'h2;
  localparam int          PAGPS_PIN7         = 7;
  localparam int          PAGPS_PIN6         = 6;

  // status field positions
  localparam int PAGPS_ST_MODE_LSB = 0;
  localparam int PAGPS_ST_FN7_LSB  = 8;
  localparam int PAGPS_ST_FN6_LSB  = 16;

  // -------------------------------------------------------------------
  // control register layout
  // -------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] b_io;       // [2] is b_side_capture_select
    logic [2:0] a_io;       // [2] is a_side_capture_select
    logic       ch2_pwm_mode_bit;
    logic       address_bit21_enable;
    logic       chip_select4_enable;
    logic       pin6_pattern_enable;
    logic       pin7_pattern_enable;
  } pagps_ctrl_t;

  localparam pagps_ctrl_t PAGPS_CTRL_RST = 11'h008;

  // -------------------------------------------------------------------
  // pin functions
  // -------------------------------------------------------------------
  typedef enum logic [5:0] {
    PAGPS_FN_IN   = 6'h01,
    PAGPS_FN_PORT = 6'h02,
    PAGPS_FN_PAT  = 6'h04,
    PAGPS_FN_TMR  = 6'h08,
    PAGPS_FN_ADDR = 6'h10,
    PAGPS_FN_CS   = 6'h20
  } pagps_fn_t;

endpackage

// File: sim/pagps_board.sv
// board model: resolves each port a pin from device drive and board level
module pagps_board (
  // device side
  input  wire logic [7:0] pa_out,
  input  wire logic [7:0] pa_oe_n,
  // board side
  input  wire logic [7:0] board_lvl,
  output logic [7:0]      pa_in
);
  timeunit 1ns;
  timeprecision 100ps;

  // -------------------------------------------------------------------
  // pin resolution
  // -------------------------------------------------------------------
  // device drive wins where its enable is low
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pa_in[i] = pa_oe_n[i] ? board_lvl[i] : pa_out[i];
    end
  end
endmodule

// File: sim/pagps_top_test.sv
// self-checking bench for the port a pin select block
module pagps_top_test
  import pagps_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // -------------------------------------------------------------------
  // signals
  // -------------------------------------------------------------------
  logic        aclk;
  logic        aresetn;
  logic [3:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [3:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic [2:0]  mode_pins;
  logic        hw_standby;
  logic        sw_standby;
  logic [6:0]  fn_src;
  logic        cap_b;
  logic        cap_a;
  logic [7:0]  pa_in;
  logic [7:0]  pa_out;
  logic [7:0]  pa_oe_n;
  logic [7:0]  board_lvl;
  int          err_count;
  int          num_checks;

  typedef struct packed {
    logic [2:0]  m;
    logic        p7;
    logic [10:0] c;
    logic [7:0]  d;
    logic        oe;
    logic        out;
    logic        cap;
  } pagps_row_t;

  // mode, pin 7?, ctrl, dir, oe_n, out, capture
  pagps_row_t rows [14] = '{
    '{3'h1, 1'h1, 11'h008, 8'h80, 1'h0, 1'h0, 1'h0},
    '{3'h1, 1'h1, 11'h009, 8'h80, 1'h0, 1'h1, 1'h0},
    '{3'h1, 1'h1, 11'h108, 8'h00, 1'h0, 1'h0, 1'h0},
    '{3'h1, 1'h1, 11'h008, 8'h00, 1'h1, 1'h0, 1'h0},
    '{3'h1, 1'h1, 11'h408, 8'h00, 1'h1, 1'h0, 1'h1},
    '{3'h1, 1'h1, 11'h418, 8'h00, 1'h0, 1'h0, 1'h0},
    '{3'h1, 1'h0, 11'h00C, 8'h00, 1'h0, 1'h0, 1'h0},
    '{3'h1, 1'h0, 11'h008, 8'h40, 1'h0, 1'h1, 1'h0},
    '{3'h1, 1'h0, 11'h00A, 8'h40, 1'h0, 1'h0, 1'h0},
    '{3'h1, 1'h0, 11'h088, 8'h00, 1'h1, 1'h0, 1'h1},
    '{3'h7, 1'h0, 11'h00C, 8'h40, 1'h0, 1'h1, 1'h0},
    '{3'h3, 1'h0, 11'h000, 8'h00, 1'h0, 1'h1, 1'h0},
    '{3'h3, 1'h0, 11'h004, 8'h00, 1'h0, 1'h0, 1'h0},
    '{3'h3, 1'h0, 11'h008, 8'h00, 1'h1, 1'h0, 1'h0}
  };

  always #4 aclk = ~aclk;

  // -------------------------------------------------------------------
  // instances
  // -------------------------------------------------------------------
  pagps_top pagps_top_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .mode_pins(mode_pins), .hw_standby(hw_standby), .sw_standby(sw_standby),
    .pattern_out_bit7(fn_src[6]), .pattern_out_bit6(fn_src[5]),
    .timer_ch2_b_out(fn_src[4]), .timer_ch2_a_out(fn_src[3]),
    .address_bit_twenty(fn_src[2]), .address_bit_twentyone(fn_src[1]),
    .chip_select_four_n(fn_src[0]),
    .timer_ch2_b_capture(cap_b), .timer_ch2_a_capture(cap_a),
    .pa_in(pa_in), .pa_out(pa_out), .pa_oe_n(pa_oe_n)
  );

  pagps_board pagps_board_i (
    .pa_out(pa_out), .pa_oe_n(pa_oe_n), .board_lvl(board_lvl), .pa_in(pa_in)
  );

  // -------------------------------------------------------------------
  // common tasks
  // -------------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic timeout(input string name);
    err_count++;
    $display("[FAIL] %s expected answer seen none", name);
    final_report();
  endtask

  task automatic settle();
    repeat (2) @(posedge aclk);
    #1;
  endtask

  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta;
    logic tw;
    logic tb;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hF;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    tb = 1'h0;
    for (int n = 0; n < 50 && !tb; n++) begin
      #1;
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid === 1'h1;
      r  = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      if (tb) s_axi_bready <= 1'h0;
    end
    if (!tb) timeout("write response");
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    logic       ta;
    logic       tr;
    logic [1:0] rr;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    tr = 1'h0;
    for (int n = 0; n < 50 && !tr; n++) begin
      #1;
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid === 1'h1;
      d  = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'h0;
      if (tr) s_axi_rready <= 1'h0;
    end
    if (!tr) timeout("read data");
    check("read resp", {30'h0, rr}, {30'h0, PAGPS_RESP_OKAY});
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    check("write resp", {30'h0, r}, {30'h0, PAGPS_RESP_OKAY});
  endtask

  task automatic do_reset(input logic [2:0] m);
    @(posedge aclk);
    aresetn   <= 1'h0;
    mode_pins <= m;
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    settle();
  endtask

  // -------------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] d;
    logic [7:0]  dr;
    for (int m = 0; m < 8; m++) begin
      do_reset(m[2:0]);
      dr = (m == 3 || m == 4 || m == 6) ? PAGPS_DIR_RST_ADDR : PAGPS_DIR_RST_LOW;
      check("reset oe", {24'h0, pa_oe_n}, {24'h0, ~dr});
      if (dr[7]) check("pin7 address", {31'h0, pa_out[7]}, 32'h1);
      rd(PAGPS_OFS_DIR, d);
      check("dir read", d, {24'h0, PAGPS_DIR_READ});
      rd(PAGPS_OFS_DATA, d);
      check("reset data", d, {24'h0, board_lvl & ~dr});
      wr(PAGPS_OFS_DIR, 32'h0);
      settle();
      check("oe after dir clear", {24'h0, pa_oe_n}, {24'h0, ~dr});
    end
  endtask

  task automatic t_fn();
    logic [2:0] cur;
    int         p;
    for (int k = 0; k < 2; k++) begin
      @(posedge aclk);
      fn_src <= k ? 7'h39 : 7'h46;
      for (int i = 0; i < 14; i++) begin
        if (i == 0 || rows[i].m != cur) begin
          cur = rows[i].m;
          do_reset(cur);
          wr(PAGPS_OFS_DATA, k ? 32'h0000_00BF : 32'h0000_0040);
        end
        p = rows[i].p7 ? PAGPS_PIN7 : PAGPS_PIN6;
        wr(PAGPS_OFS_CTRL, {21'h0, rows[i].c});
        wr(PAGPS_OFS_DIR, {24'h0, rows[i].d});
        settle();
        check("pin oe", {31'h0, pa_oe_n[p]}, {31'h0, rows[i].oe});
        if (!rows[i].oe)
          check("pin out", {31'h0, pa_out[p]}, {31'h0, rows[i].out ^ k[0]});
        check("capture", {31'h0, rows[i].p7 ? cap_b : cap_a}, {31'h0, rows[i].cap});
      end
    end
  endtask

  task automatic t_standby();
    logic [31:0] d;
    logic [1:0]  r;
    do_reset(3'h1);
    wr(PAGPS_OFS_DIR, 32'h0000_000F);
    wr(PAGPS_OFS_DATA, 32'h0000_0005);
    sw_standby <= 1'h1;
    wr(PAGPS_OFS_DATA, 32'h0000_00FF);
    wr(PAGPS_OFS_DIR, 32'h0000_0000);
    settle();
    check("sw standby oe", {24'h0, pa_oe_n}, 32'h0000_00F0);
    check("sw standby out", {28'h0, pa_out[3:0]}, 32'h0000_0005);
    rd(PAGPS_OFS_DATA, d);
    check("sw standby data", d, {24'h0, (board_lvl & 8'hF0) | 8'h05});
    sw_standby <= 1'h0;
    hw_standby <= 1'h1;
    settle();
    check("hw standby oe", {24'h0, pa_oe_n}, 32'h0000_00FF);
    @(posedge aclk);
    hw_standby <= 1'h0;
    wr(PAGPS_OFS_DIR, 32'h0000_00FF);
    rd(PAGPS_OFS_DATA, d);
    check("hw standby data", d, {24'h0, PAGPS_DATA_RST});
    axi_write(PAGPS_OFS_STATUS, 32'h0, r);
    check("status write", {30'h0, r}, {30'h0, PAGPS_RESP_SLVERR});
  endtask

  // -------------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------------
  initial begin
    aclk          = 1'h0;
    aresetn       = 1'h0;
    s_axi_awaddr  = 4'h0;
    s_axi_awvalid = 1'h0;
    s_axi_wdata   = 32'h0;
    s_axi_wstrb   = 4'h0;
    s_axi_wvalid  = 1'h0;
    s_axi_bready  = 1'h0;
    s_axi_araddr  = 4'h0;
    s_axi_arvalid = 1'h0;
    s_axi_rready  = 1'h0;
    mode_pins     = 3'h1;
    hw_standby    = 1'h0;
    sw_standby    = 1'h0;
    fn_src        = 7'h46;
    board_lvl     = 8'hE5;
    err_count     = 0;
    num_checks    = 0;
    t_reset();
    t_fn();
    t_standby();
    final_report();
  end
endmodule
